// [ofd_pkg.sv]
/*
 * ofd_pkg: constants and field carrier of the decoder.
 * assumes one core clock in which four periods make one instruction cycle.
 */
package ofd_pkg;

  // instruction cycle timing
  localparam int unsigned QUARTERS_PER_CYCLE = 4;
  localparam logic [1:0] QUARTER_LAST = 2'(QUARTERS_PER_CYCLE - 1);

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TBL_PTR = 8'h08;
  localparam logic [7:0] REG_TBL_LATCH = 8'h0c;
  localparam logic [7:0] REG_FIELDS = 8'h10;

  // field positions and reset values
  localparam int unsigned CTRL_BANK_LSB = 0;
  localparam int unsigned STATUS_STATE_LSB = 8;
  localparam int unsigned FIELDS_BIT_LSB = 12;
  localparam int unsigned FIELDS_DEST_POS = 15;
  localparam int unsigned FIELDS_TBL_LSB = 16;
  localparam int unsigned FIELDS_LIT_LSB = 18;
  localparam int unsigned FIELDS_NOP_POS = 20;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [20:0] TBL_PTR_RESET = 21'h000000;
  localparam logic [7:0] TBL_LATCH_RESET = 8'h00;
  localparam logic [4:0] FLAGS_RESET = 5'h00;

  // encodings
  localparam logic [3:0] SECOND_WORD_PREFIX = 4'hf;
  localparam logic [1:0] INDEX_POINTER = 2'h2;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

  // status flag positions
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_HC = 1;
  localparam int unsigned FLAG_Z = 2;
  localparam int unsigned FLAG_OV = 3;
  localparam int unsigned FLAG_N = 4;
  localparam logic [4:0] MASK_ALL = 5'h1f;
  localparam logic [4:0] MASK_ZN = 5'h14;
  localparam logic [4:0] MASK_CZN = 5'h15;
  localparam logic [4:0] MASK_Z = 5'h04;

  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    OFD_TBL_KEEP = 2'h0,
    OFD_TBL_POST_INC = 2'h1,
    OFD_TBL_POST_DEC = 2'h2,
    OFD_TBL_PRE_INC = 2'h3
  } ofd_tbl_mode_t;

  typedef enum logic [1:0] {
    OFD_LIT_NONE = 2'h0,
    OFD_LIT_8 = 2'h1,
    OFD_LIT_12 = 2'h2,
    OFD_LIT_20 = 2'h3
  } ofd_lit_width_t;

  typedef enum logic [2:0] {
    OFD_ST_FIRST = 3'b001,
    OFD_ST_SECOND = 3'b010,
    OFD_ST_FLUSH = 3'b100
  } ofd_state_t;

  // decoded operand fields of one instruction
  typedef struct packed {
    logic nop;
    logic [11:0] file_addr;
    logic dest_is_file;
    logic [2:0] bit_pos;
    logic [1:0] ptr_sel;
    logic [11:0] src_addr;
    logic [11:0] dst_addr;
    logic move;
    ofd_lit_width_t lit_width;
    logic [19:0] literal;
    logic relative;
    logic [19:0] branch_target;
    logic is_call;
    logic is_return;
    logic fast;
    logic tbl_read;
    logic tbl_write;
    ofd_tbl_mode_t tbl_mode;
    logic ptr_load;
    logic [4:0] flag_mask;
  } ofd_fields_t;

endpackage

// [ofd_decoder.sv]
/* ofd_decoder: operand field decoder with table pointer, shadows, flags and AXI4-Lite slave.
   assumes its neighbours run on clk_sys_in, the oscillator. */
// Functional notes
// - access bit 0: access RAM; 1: bank from bank selector
// - bit operations take 3-bit bit position 0 to 7
// - destination bit 0: accumulator; 1: file register
// - 8-bit file address, or 2-bit pointer selector for loads
// - move source: 12-bit address from first word
// - move destination: 12-bit address from second word
// - literals 8, 12 or 20 bits wide
// - table modes: keep, post-increment, post-decrement, pre-increment
// - relative branches two's-complement; calls and gotos direct
// - fast bit 1 saves or restores shadows; 0 leaves them
// - 21-bit table pointer; 8-bit table latch
// - indexed moves add 7-bit offsets to the pointer
// - don't-care bits never affect decoding
// - five flags: carry, half carry, zero, overflow, negative
// - second words start with four ones; alone they are no-operation
// - true skip or counter change makes next cycle a no-operation
`timescale 1ns/1ps
module ofd_decoder #(
  parameter logic [7:0] ACCESS_SPLIT = 8'h80
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // program memory
  input wire logic [15:0] instr_in,
  input wire logic instr_valid_in,
  output logic instr_ready_out,
  // execution feedback
  input wire logic redirect_in,
  input wire logic alu_valid_in,
  input wire logic [4:0] alu_flags_in,
  input wire logic [7:0] working_accumulator_in,
  // table memory
  input wire logic table_rvalid_in,
  input wire logic [7:0] table_rdata_in,
  output logic [20:0] table_addr_out,
  output logic [7:0] table_latch_byte_out,
  // decoded fields
  output ofd_pkg::ofd_fields_t fields_out,
  output logic cycle_start_out,
  output logic [4:0] status_flags_out,
  output logic [3:0] bank_selector_out,
  output logic shadow_restore_out,
  output logic [7:0] shadow_accumulator_out,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);
  import ofd_pkg::*;
  logic [1:0] quarter_reg, bresp_reg, rresp_reg;
  ofd_state_t state_reg, state_next;
  logic [15:0] first_word_reg;
  logic redirect_pend_reg, shadow_restore_reg, cycle_start, take_word, two_word_first, flush_now;
  logic aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg, wr_fire;
  ofd_fields_t fields_reg, fields_next;
  logic [11:0] pointer_reg [4];
  logic [20:0] tbl_ptr_reg, tbl_ptr_next;
  logic [7:0] tbl_latch_reg, shadow_acc_reg, aw_addr_reg;
  logic [4:0] flags_reg, shadow_flags_reg;
  logic [3:0] bank_reg, shadow_bank_reg, w_strb_reg;
  logic [31:0] w_data_reg, rdata_reg;
  // a redirect refuses the word at this cycle start
  assign flush_now = redirect_pend_reg || redirect_in;
  assign cycle_start = (quarter_reg == '0);
  assign instr_ready_out = cycle_start && !flush_now;
  assign take_word = instr_ready_out && instr_valid_in;
  assign cycle_start_out = cycle_start;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      quarter_reg <= '0;
    end else if (quarter_reg == QUARTER_LAST) begin
      quarter_reg <= '0;
    end else begin
      quarter_reg <= quarter_reg + 2'h1;
    end
  end
  // first word of a two-word instruction
  always_comb begin
    two_word_first = 1'b0;
    casez (instr_in[15:8])
      8'b1100_????: two_word_first = 1'b1;
      8'b1110_1111: two_word_first = 1'b1;
      8'b1110_110?: two_word_first = 1'b1;
      8'b1110_1011: two_word_first = 1'b1;
      8'b1110_1110: two_word_first = (instr_in[7:6] == 2'b00);
      default: two_word_first = 1'b0;
    endcase
  end
  always_comb begin
    fields_next = '0;
    fields_next.nop = 1'b1;
    state_next = (state_reg == OFD_ST_SECOND) ? OFD_ST_SECOND : OFD_ST_FIRST;
    if (flush_now) begin
      fields_next.nop = 1'b1;
    end else if (state_reg == OFD_ST_SECOND && instr_valid_in) begin
      state_next = OFD_ST_FIRST;
      fields_next.nop = 1'b0;
      casez (first_word_reg[15:6])
        10'b1100_??????: begin
          fields_next.move = 1'b1;
          fields_next.src_addr = first_word_reg[11:0];
          fields_next.dst_addr = instr_in[11:0];
        end
        10'b1110_1111_??: begin
          fields_next.lit_width = OFD_LIT_20;
          fields_next.literal = {instr_in[11:0], first_word_reg[7:0]};
          fields_next.branch_target = {instr_in[11:0], first_word_reg[7:0]};
        end
        10'b1110_110?_??: begin
          fields_next.lit_width = OFD_LIT_20;
          fields_next.literal = {instr_in[11:0], first_word_reg[7:0]};
          fields_next.branch_target = {instr_in[11:0], first_word_reg[7:0]};
          fields_next.is_call = 1'b1;
          fields_next.fast = first_word_reg[8];
        end
        10'b1110_1110_00: begin
          fields_next.ptr_load = 1'b1;
          fields_next.ptr_sel = first_word_reg[5:4];
          fields_next.lit_width = OFD_LIT_12;
          fields_next.literal = {8'h00, first_word_reg[3:0], instr_in[7:0]};
        end
        10'b1110_1011_??: begin
          fields_next.move = 1'b1;
          fields_next.src_addr = pointer_reg[INDEX_POINTER] + {5'h00, first_word_reg[6:0]};
          fields_next.dst_addr = first_word_reg[7] ? pointer_reg[INDEX_POINTER] + {5'h00, instr_in[6:0]}
                                                   : instr_in[11:0];
        end
        default: fields_next.nop = 1'b1;
      endcase
    end else if (state_reg != OFD_ST_SECOND && instr_valid_in) begin
      if (two_word_first) begin
        state_next = OFD_ST_SECOND;
      end else if (instr_in[15:12] != SECOND_WORD_PREFIX) begin
        fields_next.nop = 1'b0;
        fields_next.file_addr = instr_in[8] ? {bank_reg, instr_in[7:0]}
                              : (instr_in[7:0] < ACCESS_SPLIT ? {4'h0, instr_in[7:0]}
                                                             : {ACCESS_HIGH_BANK, instr_in[7:0]});
        casez (instr_in[15:8])
          8'b0000_0000: begin
            fields_next.tbl_read = (instr_in[7:2] == 6'b000010);
            fields_next.tbl_write = (instr_in[7:2] == 6'b000011);
            fields_next.tbl_mode = ofd_tbl_mode_t'(instr_in[1:0]);
            fields_next.is_return = (instr_in[7:2] == 6'b000100);
            fields_next.fast = (instr_in[7:2] == 6'b000100) && instr_in[0];
          end
          8'b0000_0001, 8'b0000_1???: begin
            fields_next.lit_width = OFD_LIT_8;
            fields_next.literal = {12'h000, instr_in[7:0]};
          end
          8'b1101_????: begin
            fields_next.relative = 1'b1;
            fields_next.branch_target = {{9{instr_in[10]}}, instr_in[10:0]};
          end
          8'b1110_0???: begin
            fields_next.relative = 1'b1;
            fields_next.branch_target = {{12{instr_in[7]}}, instr_in[7:0]};
          end
          8'b100?_????, 8'b101?_????, 8'b0111_????: begin
            fields_next.bit_pos = instr_in[11:9];
          end
          8'b0010_????, 8'b0000_01??, 8'b0101_????, 8'b0110_110?: begin
            fields_next.dest_is_file = instr_in[9];
            fields_next.flag_mask = (instr_in[15:10] == 6'b0101_00 || instr_in[15:10] == 6'b0010_11)
                                  ? (instr_in[11:10] == 2'b00 ? MASK_ZN : 5'h00) : MASK_ALL;
          end
          8'b0001_????, 8'b0100_0???: begin
            fields_next.dest_is_file = instr_in[9];
            fields_next.flag_mask = MASK_ZN;
          end
          8'b0011_0???: begin
            fields_next.dest_is_file = instr_in[9];
            fields_next.flag_mask = MASK_CZN;
          end
          8'b0110_101?: fields_next.flag_mask = MASK_Z;
          default: fields_next.dest_is_file = instr_in[9];
        endcase
      end
    end
  end
  // fields held for a whole instruction cycle
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fields_reg <= '0;
      state_reg <= OFD_ST_FIRST;
    end else if (cycle_start) begin
      fields_reg <= fields_next;
      state_reg <= flush_now ? OFD_ST_FLUSH : state_next;
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      first_word_reg <= '0;
    end else if (take_word && state_reg != OFD_ST_SECOND) begin
      first_word_reg <= instr_in;
    end
  end
  // a redirect seen mid-cycle forces the next cycle empty
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      redirect_pend_reg <= 1'b0;
    end else if (cycle_start) begin
      redirect_pend_reg <= 1'b0;
    end else if (redirect_in) begin
      redirect_pend_reg <= 1'b1;
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pointer_reg <= '{default: 12'h000};
    end else if (cycle_start && fields_next.ptr_load && !fields_next.nop) begin
      pointer_reg[fields_next.ptr_sel] <= fields_next.literal[11:0];
    end
  end
  always_comb begin
    tbl_ptr_next = tbl_ptr_reg;
    unique case (fields_next.tbl_mode)
      OFD_TBL_KEEP: tbl_ptr_next = tbl_ptr_reg;
      OFD_TBL_POST_INC, OFD_TBL_PRE_INC: tbl_ptr_next = tbl_ptr_reg + 21'h000001;
      OFD_TBL_POST_DEC: tbl_ptr_next = tbl_ptr_reg - 21'h000001;
    endcase
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tbl_ptr_reg <= TBL_PTR_RESET;
      table_addr_out <= TBL_PTR_RESET;
    end else if (cycle_start && (fields_next.tbl_read || fields_next.tbl_write) && !fields_next.nop) begin
      tbl_ptr_reg <= tbl_ptr_next;
      table_addr_out <= (fields_next.tbl_mode == OFD_TBL_PRE_INC) ? tbl_ptr_next : tbl_ptr_reg;
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tbl_latch_reg <= TBL_LATCH_RESET;
    end else if (table_rvalid_in && fields_reg.tbl_read) begin
      tbl_latch_reg <= table_rdata_in;
    end
  end
  // shadow copies for fast call and return
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shadow_acc_reg <= '0;
      shadow_flags_reg <= FLAGS_RESET;
      shadow_bank_reg <= BANK_RESET;
    end else if (cycle_start && fields_next.is_call && fields_next.fast && !fields_next.nop) begin
      shadow_acc_reg <= working_accumulator_in;
      shadow_flags_reg <= flags_reg;
      shadow_bank_reg <= bank_reg;
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shadow_restore_reg <= 1'b0;
    end else begin
      shadow_restore_reg <= cycle_start && fields_next.is_return && fields_next.fast && !fields_next.nop;
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flags_reg <= FLAGS_RESET;
    end else if (shadow_restore_reg) begin
      flags_reg <= shadow_flags_reg;
    end else if (alu_valid_in) begin
      flags_reg <= (flags_reg & ~fields_reg.flag_mask) | (alu_flags_in & fields_reg.flag_mask);
    end
  end
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bank_reg <= BANK_RESET;
    end else if (shadow_restore_reg) begin
      bank_reg <= shadow_bank_reg;
    end else if (wr_fire && aw_addr_reg == REG_CTRL && w_strb_reg[0]) begin
      bank_reg <= w_data_reg[CTRL_BANK_LSB +: 4];
    end
  end
  // axi write channels, taken in either order
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid_in && !aw_held_reg) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr_in;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (s_axi_wvalid_in && !w_held_reg) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata_in;
      w_strb_reg <= s_axi_wstrb_in;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= AXI_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (aw_addr_reg == REG_CTRL) ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready_in) begin
      bvalid_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= AXI_OKAY;
    end else if (s_axi_arvalid_in && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= AXI_OKAY;
      unique case (s_axi_araddr_in)
        REG_CTRL: rdata_reg <= {28'h0000000, bank_reg};
        REG_STATUS: rdata_reg <= {21'h000000, 3'(state_reg), 3'h0, flags_reg};
        REG_TBL_PTR: rdata_reg <= {11'h000, tbl_ptr_reg};
        REG_TBL_LATCH: rdata_reg <= {24'h000000, tbl_latch_reg};
        REG_FIELDS: rdata_reg <= {11'h000, fields_reg.nop, fields_reg.lit_width, fields_reg.tbl_mode,
                                  fields_reg.dest_is_file, fields_reg.bit_pos, fields_reg.file_addr};
        default: begin
          rdata_reg <= '0;
          rresp_reg <= AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rready_in) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_awready_out = !aw_held_reg;
  assign s_axi_wready_out = !w_held_reg;
  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_bresp_out = bresp_reg;
  assign s_axi_arready_out = !rvalid_reg;
  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rdata_out = rdata_reg;
  assign s_axi_rresp_out = rresp_reg;
  assign fields_out = fields_reg;
  assign status_flags_out = flags_reg;
  assign bank_selector_out = bank_reg;
  assign table_latch_byte_out = tbl_latch_reg;
  assign shadow_restore_out = shadow_restore_reg;
  assign shadow_accumulator_out = shadow_acc_reg;
endmodule // ofd_decoder

// [ofd_decoder_props.sv]
/* ofd_decoder_props: port checks of the decoder.
   assumes a bind to each ofd_decoder. */
`timescale 1ns/1ps
module ofd_decoder_props #(
  parameter logic [7:0] ACCESS_SPLIT = 8'h80
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // watched ports
  input wire logic [15:0] instr_in,
  input wire logic instr_valid_in,
  input wire logic instr_ready_out,
  input wire logic redirect_in,
  input wire logic alu_valid_in,
  input wire logic [4:0] alu_flags_in,
  input wire logic [3:0] bank_selector_out,
  input wire ofd_pkg::ofd_fields_t fields_out,
  input wire logic cycle_start_out,
  input wire logic [4:0] status_flags_out,
  input wire logic shadow_restore_out
);
  import ofd_pkg::*;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  sequence take_s;
    cycle_start_out && instr_ready_out && instr_valid_in;
  endsequence
  sequence take_byte_s;
    take_s ##0 (instr_in[15:10] == 6'b001001);
  endsequence
  a_ready_quarter:
    assert property (instr_ready_out |-> cycle_start_out) else $error("ready late");
  a_cycle_period:
    assert property (cycle_start_out |=> !cycle_start_out [*3] ##1 cycle_start_out) else $error("bad cycle");
  a_fields_held:
    assert property (!cycle_start_out |=> $stable(fields_out)) else $error("fields moved");
  a_redirect_nop:
    assert property (redirect_in |-> ##[1:4] (cycle_start_out && !instr_ready_out) ##1 fields_out.nop)
      else $error("no flush");
  a_file_addr:
    assert property (take_byte_s |=> fields_out.file_addr == ($past(instr_in[8]) ?
      {$past(bank_selector_out), $past(instr_in[7:0])} :
      {($past(instr_in[7:0]) < ACCESS_SPLIT) ? 4'h0 : ACCESS_HIGH_BANK, $past(instr_in[7:0])}))
      else $error("file addr");
  a_dest_route:
    assert property (take_byte_s |=> fields_out.dest_is_file == $past(instr_in[9]) && !fields_out.nop)
      else $error("dest");
  a_bit_pos:
    assert property (take_s ##0 (instr_in[15:12] == 4'h8) |=> fields_out.bit_pos == $past(instr_in[11:9]))
      else $error("bit pos");
  a_literal_byte:
    assert property (take_s ##0 (instr_in[15:8] == 8'h0e) |=> fields_out.lit_width == OFD_LIT_8 &&
      fields_out.literal[7:0] == $past(instr_in[7:0])) else $error("literal");
  a_flags_mask:
    assert property (alu_valid_in |=> shadow_restore_out ||
      ((((status_flags_out ^ $past(alu_flags_in)) & $past(fields_out.flag_mask)) == 5'h00) &&
      (((status_flags_out ^ $past(status_flags_out)) & ~$past(fields_out.flag_mask)) == 5'h00)))
      else $error("flags");
  a_fast_restore:
    assert property (take_s ##0 (instr_in == 16'h0013) |-> ##[1:2] shadow_restore_out) else $error("no restore");
  a_plain_return:
    assert property (take_s ##0 (instr_in == 16'h0012) |=> !shadow_restore_out [*3]) else $error("stray restore");
endmodule // ofd_decoder_props

bind ofd_decoder ofd_decoder_props #(.ACCESS_SPLIT(ACCESS_SPLIT)) props_u (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .instr_in(instr_in), .instr_valid_in(instr_valid_in),
  .instr_ready_out(instr_ready_out), .redirect_in(redirect_in), .alu_valid_in(alu_valid_in),
  .alu_flags_in(alu_flags_in), .bank_selector_out(bank_selector_out), .fields_out(fields_out),
  .cycle_start_out(cycle_start_out), .status_flags_out(status_flags_out), .shadow_restore_out(shadow_restore_out));

// [ofd_prog_mem.sv]
/* ofd_prog_mem: program memory model with a word queue.
   assumes words are taken at a cycle start with ready high. */
`timescale 1ns/1ps
module ofd_prog_mem (
  // clock
  input wire logic clk_sys_in,
  // decoder handshake
  input wire logic cycle_start_in,
  input wire logic ready_in,
  output logic [15:0] instr_out,
  output logic valid_out,
  output int taken_out
);
  logic [15:0] queue_q[$];
  initial begin
    instr_out = 16'h0000;
    valid_out = 1'b0;
    taken_out = 0;
  end
  task load(input logic [15:0] word);
    queue_q.push_back(word);
  endtask
  // a word stays until taken; an empty bus toggles so stale data never looks valid
  always @(posedge clk_sys_in) begin
    if (valid_out && cycle_start_in && ready_in) begin
      void'(queue_q.pop_front());
      taken_out <= taken_out + 1;
    end
    valid_out <= queue_q.size() != 0;
    instr_out <= (queue_q.size() != 0) ? queue_q[0] : ~instr_out;
  end
endmodule // ofd_prog_mem

// [ofd_decoder_tb.sv]
/* ofd_decoder_tb: self-checking bench of the decoder.
   assumes ofd_prog_mem and the bound checker. */
`timescale 1ns/1ps
module ofd_decoder_tb;
  import ofd_pkg::*;
  localparam logic [7:0] SPLIT = 8'h80;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic redirect = 1'b0, alu_valid = 1'b0, trvalid = 1'b0;
  logic [4:0] alu_flags = 5'h00, flags, fl;
  logic [7:0] acc = 8'h00, trdata = 8'h00, awaddr = 8'h00, araddr = 8'h00, tlatch, sacc;
  logic [31:0] wdata = 32'h0, seed = 32'h24, r, rd, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic ivalid, iready, cs, srest, awready, wready, bvalid, arready, rvalid;
  logic [15:0] instr;
  logic [20:0] taddr, p, ea;
  logic [3:0] bank, bw;
  logic [1:0] bresp, rresp, rs;
  ofd_fields_t f;
  int fail_count = 0;
  int checked = 0;
  int taken, t0;
  initial begin
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  ofd_prog_mem pm_u (.clk_sys_in(clk_sys_in), .cycle_start_in(cs), .ready_in(iready), .instr_out(instr),
    .valid_out(ivalid), .taken_out(taken));
  ofd_decoder #(.ACCESS_SPLIT(SPLIT)) dut_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .instr_in(instr),
    .instr_valid_in(ivalid), .instr_ready_out(iready), .redirect_in(redirect), .alu_valid_in(alu_valid),
    .alu_flags_in(alu_flags), .working_accumulator_in(acc), .table_rvalid_in(trvalid), .table_rdata_in(trdata),
    .table_addr_out(taddr), .table_latch_byte_out(tlatch), .fields_out(f), .cycle_start_out(cs),
    .status_flags_out(flags), .bank_selector_out(bank), .shadow_restore_out(srest), .shadow_accumulator_out(sacc),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready));
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic [11:0] exp_addr(input logic [15:0] w);
    return w[8] ? {bw, w[7:0]} : {(w[7:0] < SPLIT) ? 4'h0 : ACCESS_HIGH_BANK, w[7:0]};
  endfunction
  task complete_run();
    $display("counts: fail_count=%0d checked=%0d", fail_count, checked);
    if (fail_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task give_up();
    fail_count++;
    $display("MISMATCH t=%0t wait ran out", $time);
    complete_run();
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wait_take(input int n0);
    for (int k = 0; k < 40 && taken == n0; k++) @(negedge clk_sys_in);
    if (taken == n0) give_up();
  endtask
  task exec(input logic [15:0] w);
    int n0;
    n0 = taken;
    pm_u.load(w);
    wait_take(n0);
  endtask
  task alu(input logic [4:0] v);
    @(posedge clk_sys_in);
    alu_flags <= v;
    alu_valid <= 1'b1;
    @(posedge clk_sys_in);
    alu_valid <= 1'b0;
    @(negedge clk_sys_in);
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (k == 50) give_up();
    rs = bresp;
    bready <= 1'b0;
  endtask
  task axi_rd(input logic [7:0] a);
    int k;
    @(posedge clk_sys_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys_in);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (k == 50) give_up();
    rs = rresp;
    rd = rdata;
    rready <= 1'b0;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    axi_rd(REG_STATUS);
    cmp(rd, 32'h0000_0100);
    r = rnd();
    bw = r[3:0];
    axi_wr(REG_CTRL, {28'h0, bw});
    cmp(rs, AXI_OKAY);
    axi_rd(REG_CTRL);
    cmp(rd, {28'h0, bw});
    axi_wr(REG_STATUS, 32'h1f);
    cmp(rs, AXI_SLVERR);
    axi_rd(8'h20);
    cmp(rs, AXI_SLVERR);
    cmp(rd, 32'h0);
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      if (i < 2) r[9:0] = 10'h07f + 10'(i);
      fl = r[14:10];
      exec({6'b001001, r[9:0]});
      cmp(f.file_addr, exp_addr(r[15:0]));
      cmp(f.dest_is_file, r[9]);
      alu(fl);
      cmp(flags, fl);
      exec({6'b000101, r[9:0]});
      alu(~fl);
      cmp(flags, (fl & ~MASK_ZN) | (~fl & MASK_ZN));
      exec({4'h8, r[11:0]});
      cmp(f.bit_pos, r[11:9]);
      exec({8'h0e, r[23:16]});
      cmp(f.literal[7:0], r[23:16]);
    end
    r = rnd();
    exec({4'hc, r[11:0]});
    cmp(f.nop, 1'b1);
    exec({4'hf, r[27:16]});
    cmp({f.move, f.src_addr}, {1'b1, r[11:0]});
    cmp(f.dst_addr, r[27:16]);
    exec({4'hf, r[11:0]});
    cmp(f.nop, 1'b1);
    exec({8'hef, r[7:0]});
    exec({4'hf, r[19:8]});
    cmp({f.relative, f.branch_target}, {1'b0, r[19:0]});
    exec({5'b11010, r[10:0]});
    cmp(f.relative, 1'b1);
    exec({8'hee, 2'b00, r[5:4], r[3:0]});
    exec({8'hf0, r[7:0]});
    cmp({f.ptr_load, f.ptr_sel}, {1'b1, r[5:4]});
    @(posedge clk_sys_in);
    acc <= r[7:0];
    exec({8'hed, r[15:8]});
    exec(16'hf000);
    cmp({f.is_call, f.fast}, 2'b11);
    @(posedge clk_sys_in);
    acc <= ~r[7:0];
    exec(16'h0013);
    for (int k = 0; k < 8 && srest !== 1'b1; k++) @(negedge clk_sys_in);
    cmp(sacc, r[7:0]);
    exec(16'h0012);
    cmp(f.fast, 1'b0);
    exec(16'h0000);
    @(posedge clk_sys_in);
    redirect <= 1'b1;
    t0 = taken;
    pm_u.load({8'h0e, r[31:24]});
    @(posedge clk_sys_in);
    redirect <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    cmp({f.nop, taken[30:0]}, {1'b1, t0[30:0]});
    wait_take(t0);
    cmp(f.literal[7:0], r[31:24]);
    p = 21'h0;
    for (int m = 0; m < 4; m++) begin
      r = rnd();
      ea = (m == 3) ? p + 21'h1 : p;
      exec(16'h0008 | 16'(m));
      @(posedge clk_sys_in);
      trvalid <= 1'b1;
      trdata <= r[7:0];
      @(posedge clk_sys_in);
      trvalid <= 1'b0;
      @(negedge clk_sys_in);
      cmp({f.tbl_read, f.tbl_mode, taddr}, {1'b1, 2'(m), ea});
      cmp(tlatch, r[7:0]);
      p = (m == 2) ? p - 21'h1 : ((m == 0) ? p : p + 21'h1);
    end
    axi_rd(REG_TBL_PTR);
    cmp(rd, {11'h0, p});
    exec(16'h000d);
    cmp({f.tbl_write, f.tbl_mode}, {1'b1, OFD_TBL_POST_INC});
    repeat (8) @(posedge clk_sys_in);
    complete_run();
  end
endmodule // ofd_decoder_tb
